// >>> rtl/sbp_consts.vh
/*
 Constants for the secondary bus power state controller.
 Assumes inclusion by bare name from rtl/ design files.
*/
`ifndef SBP_CONSTS_VH
`define SBP_CONSTS_VH
// Function power state encodings
`define SBP_FS_ON 2'h0
`define SBP_FS_INT1 2'h1
`define SBP_FS_INT2 2'h2
`define SBP_FS_SOFT_OFF 2'h3
// Bus state encodings
`define SBP_BUS_FULL_ON 2'h0
`define SBP_BUS_IDLE_CLOCKED 2'h1
`define SBP_BUS_CLOCK_STOPPED 2'h2
`define SBP_BUS_UNPOWERED 2'h3
// Timing
`define SBP_CLK_MHZ 100
`define SBP_SETTLE_NS 200
`define SBP_RST_NS 1000
`define SBP_PWR_UP_NS 1000
`define SBP_CLK_HALF 5
`endif

// >>> rtl/sbp_counter.v
/*
 Down counter used for settle, power-up and reset hold times.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sbp_counter #(
   parameter W = 16
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Control
   input wire load,
   input wire [W-1:0] load_val,
   // Status
   output reg done
);
   reg [W-1:0] cnt_reg;
   always @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= {W{1'b0}};
         done <= 1'b1;
      end else if (load) begin
         cnt_reg <= load_val;
         done <= 1'b0;
      end else if (cnt_reg != {W{1'b0}}) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
         done <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
      end else begin
         done <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/sbp_ctrl.v
/*
 Secondary bus power state controller: tracks the bridge function power
 state, gates the secondary clock glitch-free, switches supply and
 drives the bus segment reset.
 Assumes bus_idle comes from the bridge's arbiter logic on core_clk and
 the strap inputs are static pins from outside the clock's domain.
*/
// Contract
// - Full on: supply applied, clock running
// - Full on is the reset state
// - Data transactions allowed only in full on
// - Idle clocked: power, clock, no transactions
// - Clock stopped: power on, clock held low
// - Unpowered: supply removed, no clock
// - Low states hold bus signals valid; sec_bus_hold covers idle clocked and clock stopped, not unpowered
// - Wait bus idle before leaving full on
// - Restoring supply asserts segment reset
// - Unpowered entered by programming optional
// - One supply and one clock for all
// - Power state field two-bit encoding
// - Bus state tracks function state
// - Hot-off select picks stopped or unpowered
// - Enable low: field leaves supply, clock
`timescale 1ns/1ns
`default_nettype none
`include "sbp_consts.vh"
module sbp_ctrl #(
   parameter SETTLE_CYC = (`SBP_SETTLE_NS * `SBP_CLK_MHZ + 999) / 1000,
   parameter PWR_UP_CYC = (`SBP_PWR_UP_NS * `SBP_CLK_MHZ + 999) / 1000,
   parameter RST_CYC = (`SBP_RST_NS * `SBP_CLK_MHZ + 999) / 1000,
   parameter CLK_HALF = `SBP_CLK_HALF
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Function power state from configuration side
   input wire [1:0] power_state_field,
   // Straps
   input wire hot_off_bus_select,
   input wire bus_pwr_clk_ctl_enable,
   // Bus status from the bridge
   input wire bus_idle,
   // Secondary bus controls
   output reg sec_clk,
   output reg sec_pwr_en,
   output reg sec_rst_n,
   output reg sec_bus_hold,
   output reg txn_allowed,
   output reg [1:0] bus_state
);
   // ****************************************
   // Strap synchronisers
   // ****************************************
   // Both straps take the same two-stage path, one pair of stages per bit
   localparam N_STRAP = 2;
   localparam STRAP_SEL = 0;
   localparam STRAP_EN = 1;
   wire [N_STRAP-1:0] strap_pin = {bus_pwr_clk_ctl_enable, hot_off_bus_select};
   wire [N_STRAP-1:0] strap_sync;
   genvar gi;
   generate
      for (gi = 0; gi < N_STRAP; gi = gi + 1) begin : g_strap
         reg s1_reg;
         reg s2_reg;
         always @(posedge core_clk) begin
            if (rst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
            end else begin
               s1_reg <= strap_pin[gi];
               s2_reg <= s1_reg;
            end
         end
         assign strap_sync[gi] = s2_reg;
      end
   endgenerate
   wire sel_sync = strap_sync[STRAP_SEL];
   wire en_sync = strap_sync[STRAP_EN];

   // ****************************************
   // Target bus state decode
   // ****************************************
   function [1:0] target_state;
      input [1:0] fs;
      input sel;
      begin
         case (fs)
            `SBP_FS_ON: target_state = `SBP_BUS_FULL_ON;
            `SBP_FS_INT1: target_state = `SBP_BUS_IDLE_CLOCKED;
            `SBP_FS_INT2: target_state = `SBP_BUS_CLOCK_STOPPED;
            `SBP_FS_SOFT_OFF: target_state = sel ? `SBP_BUS_CLOCK_STOPPED :
               `SBP_BUS_UNPOWERED;
            default: target_state = `SBP_BUS_FULL_ON;
         endcase
      end
   endfunction

   // Enable low keeps the bus at full on; another mechanism owns it
   wire [1:0] tgt = en_sync ? target_state(power_state_field, sel_sync) :
      `SBP_BUS_FULL_ON;

   // ****************************************
   // Sequencer
   // ****************************************
   // ON: bus usable, transactions open
   // SETTLE: waiting for an unbroken idle stretch before a low state
   // LOW: parked in the low state held in cur_reg
   // PWR_UP: supply ramping with segment reset held, no clock
   // RESET: clock running with segment reset held, then full on
   localparam ST_ON = 3'h0;
   localparam ST_SETTLE = 3'h1;
   localparam ST_LOW = 3'h2;
   localparam ST_PWR_UP = 3'h3;
   localparam ST_RESET = 3'h4;

   // Supply is off only while parked in the unpowered low state
   function is_unpowered;
      input [2:0] st;
      input [1:0] cur;
      begin
         is_unpowered = (st == ST_LOW) && (cur == `SBP_BUS_UNPOWERED);
      end
   endfunction

   // Clock runs in every state but ramp-up and the stopped and unpowered ones
   function clk_wanted;
      input [2:0] st;
      input [1:0] cur;
      begin
         case (st)
            ST_ON: clk_wanted = 1'b1;
            ST_SETTLE: clk_wanted = 1'b1;
            ST_RESET: clk_wanted = 1'b1;
            ST_LOW: clk_wanted = (cur == `SBP_BUS_IDLE_CLOCKED);
            default: clk_wanted = 1'b0;
         endcase
      end
   endfunction

   reg [2:0] st_reg, st_next;
   reg [1:0] cur_reg, cur_next;
   reg ld;
   reg [15:0] ld_val;
   wire cnt_done;
   wire clk_low_phase;

   // One timer serves settle, ramp-up and reset hold in turn
   sbp_counter #(.W(16)) u_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .load(ld),
      .load_val(ld_val),
      .done(cnt_done)
   );

   always @* begin
      st_next = st_reg;
      cur_next = cur_reg;
      ld = 1'b0;
      ld_val = 16'h0000;
      case (st_reg)
         ST_ON: begin
            if (tgt != `SBP_BUS_FULL_ON) begin
               st_next = ST_SETTLE;
               ld = 1'b1;
               ld_val = SETTLE_CYC[15:0];
            end
         end
         ST_SETTLE: begin
            // Bus must be idle for the whole settle time
            if (tgt == `SBP_BUS_FULL_ON) begin
               st_next = ST_ON;
            end else if (!bus_idle) begin
               ld = 1'b1;
               ld_val = SETTLE_CYC[15:0];
            end else if (cnt_done) begin
               st_next = ST_LOW;
               cur_next = tgt;
            end
         end
         ST_LOW: begin
            // Leaving unpowered always passes ramp-up and reset hold
            if (tgt == `SBP_BUS_FULL_ON) begin
               if (cur_reg == `SBP_BUS_UNPOWERED) begin
                  st_next = ST_PWR_UP;
                  ld = 1'b1;
                  ld_val = PWR_UP_CYC[15:0];
               end else begin
                  st_next = ST_ON;
                  cur_next = `SBP_BUS_FULL_ON;
               end
            end else if (tgt != cur_reg) begin
               if (cur_reg == `SBP_BUS_UNPOWERED) begin
                  st_next = ST_PWR_UP;
                  ld = 1'b1;
                  ld_val = PWR_UP_CYC[15:0];
               end else begin
                  cur_next = tgt;
               end
            end
         end
         ST_PWR_UP: begin
            if (cnt_done) begin
               st_next = ST_RESET;
               ld = 1'b1;
               ld_val = RST_CYC[15:0];
            end
         end
         ST_RESET: begin
            if (cnt_done) begin
               st_next = ST_ON; // Then settles back via normal tracking
               cur_next = `SBP_BUS_FULL_ON;
            end
         end
         default: begin
            st_next = ST_ON;
            cur_next = `SBP_BUS_FULL_ON;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         st_reg <= ST_ON;
         cur_reg <= `SBP_BUS_FULL_ON;
      end else begin
         st_reg <= st_next;
         cur_reg <= cur_next;
      end
   end

   // ****************************************
   // Secondary clock divider and gate
   // ****************************************
   reg [7:0] div_reg;
   reg ph_reg;
   // One gated clock serves the whole segment
   wire clk_run_req = clk_wanted(st_reg, cur_reg);
   assign clk_low_phase = !ph_reg;
   wire tick = (div_reg == CLK_HALF[7:0] - 8'h01);

   always @(posedge core_clk) begin
      if (rst) begin
         div_reg <= 8'h00;
         ph_reg <= 1'b0;
         sec_clk <= 1'b0;
      end else begin
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
         if (tick) begin
            // Only rise from a full low phase; fall always completes
            if (ph_reg) begin
               ph_reg <= 1'b0;
            end else if (clk_run_req) begin
               ph_reg <= 1'b1;
            end
         end
         sec_clk <= ph_reg; // Held low when stopped
      end
   end

   // ****************************************
   // Supply switch and segment reset
   // ****************************************
   // Supply drops only once the gated clock sits in its low phase
   always @(posedge core_clk) begin
      if (rst) begin
         sec_pwr_en <= 1'b1;
      end else begin
         sec_pwr_en <= !(is_unpowered(st_reg, cur_reg) && clk_low_phase);
      end
   end

   // Segment reset held while off, through ramp-up and reset hold
   always @(posedge core_clk) begin
      if (rst) begin
         sec_rst_n <= 1'b0;
      end else begin
         sec_rst_n <= !((st_reg == ST_PWR_UP) || (st_reg == ST_RESET) ||
            is_unpowered(st_reg, cur_reg));
      end
   end

   // ****************************************
   // Bus status outputs
   // ****************************************
   always @(posedge core_clk) begin
      if (rst) begin
         sec_bus_hold <= 1'b0;
         txn_allowed <= 1'b0;
         bus_state <= `SBP_BUS_FULL_ON;
      end else begin
         sec_bus_hold <= (st_reg == ST_LOW) &&
            (cur_reg != `SBP_BUS_UNPOWERED);
         // Transactions close as soon as a lower target appears
         txn_allowed <= (st_reg == ST_ON) && (tgt == `SBP_BUS_FULL_ON);
         bus_state <= cur_reg;
      end
   end
endmodule
`default_nettype wire

// >>> tb/sbp_ctrl_monitor.sv
/* Port checker for sbp_ctrl.
   Assumes a bind onto each sbp_ctrl instance. */
`timescale 1ns/1ns
`default_nettype none
module sbp_ctrl_monitor #(
   parameter CLK_HALF = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Bus side
   input wire logic bus_idle,
   input wire logic sec_clk,
   input wire logic sec_pwr_en,
   input wire logic sec_rst_n,
   input wire logic txn_allowed,
   input wire logic [1:0] bus_state
);
   logic last_reg = 1'b0;
   logic [7:0] run_reg = 8'h0;
   // Length of the phase that sec_clk just left
   always @(posedge core_clk) begin
      if (rst) begin
         last_reg <= 1'b0;
         run_reg <= 8'h0;
      end else begin
         last_reg <= sec_clk;
         run_reg <= (sec_clk != last_reg) ? 8'h1 : run_reg + {7'h0, run_reg != 8'hff};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_stopped;
      bus_state == 2'h2 [*8];
   endsequence
   sequence s_rst_held;
      !sec_rst_n [*8];
   endsequence
   a_reset_full_on: assert property (disable iff (1'b0)
      $fell(rst) |-> bus_state == 2'h0 && sec_pwr_en) else $error("not full on at reset");
   a_full_on_clock: assert property (
      txn_allowed |-> ##[0:12] sec_clk) else $error("clock idle in full on");
   a_txn_full_on: assert property (
      txn_allowed |-> bus_state == 2'h0 && sec_pwr_en && sec_rst_n) else $error("txn outside on");
   a_settle_exit: assert property (
      (bus_state != 2'h0 && $past(bus_state) == 2'h0) |-> $past(bus_idle, 4) && !$past(txn_allowed))
      else $error("left full on unsettled");
   a_stop_clk_low: assert property (
      s_stopped |-> !sec_clk) else $error("clock runs when stopped");
   a_unpowered_off: assert property (
      !sec_pwr_en |-> bus_state == 2'h3 && !sec_clk) else $error("supply off outside unpowered");
   a_pwrup_reset: assert property (
      $rose(sec_pwr_en) |-> s_rst_held) else $error("no reset on power up");
   a_no_runt: assert property (
      sec_clk != last_reg |-> run_reg >= CLK_HALF) else $error("short clock phase");
endmodule
bind sbp_ctrl sbp_ctrl_monitor #(.CLK_HALF(CLK_HALF)) u_mon (.core_clk(core_clk), .rst(rst),
   .bus_idle(bus_idle), .sec_clk(sec_clk), .sec_pwr_en(sec_pwr_en), .sec_rst_n(sec_rst_n),
   .txn_allowed(txn_allowed), .bus_state(bus_state));
`default_nettype wire

// >>> tb/sbp_func_model.sv
/* Model of the functions on the secondary bus.
   Assumes want comes from the bench. */
`timescale 1ns/1ns
`default_nettype none
module sbp_func_model (
   // Clock
   input wire logic core_clk,
   // Bus side
   input wire logic sec_pwr_en,
   input wire logic sec_rst_n,
   input wire logic txn_allowed,
   input wire logic want,
   output logic bus_idle
);
   logic [1:0] busy_reg = 2'h0;
   logic [3:0] hold_reg = 4'h0;
   assign bus_idle = busy_reg == 2'h0;
   // Access held back for a while after the bus returns to full on
   always @(posedge core_clk) begin
      if (!txn_allowed)
         hold_reg <= 4'h8;
      else if (hold_reg != 4'h0)
         hold_reg <= hold_reg - 4'h1;
   end
   // Starts short transfers only while the bus accepts them
   always @(posedge core_clk) begin
      if (busy_reg != 2'h0)
         busy_reg <= busy_reg - 2'h1;
      else if (want && txn_allowed && sec_pwr_en && sec_rst_n && hold_reg == 4'h0)
         busy_reg <= 2'h3;
   end
endmodule
`default_nettype wire

// >>> tb/test_sbp_ctrl.sv
/* Self-checking bench for sbp_ctrl.
   Assumes default timing parameters. */
`timescale 1ns/1ns
`default_nettype none
module test_sbp_ctrl;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] field = 2'h0;
   logic sel = 1'b1;
   logic en = 1'b1;
   logic want = 1'b0;
   wire bus_idle, sec_clk, sec_pwr_en, sec_rst_n, sec_bus_hold, txn_allowed;
   wire [1:0] bus_state;
   int errors = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'hf90e;
   logic [1:0] prev = 2'h0;
   sbp_ctrl DUT (.core_clk(core_clk), .rst(rst), .power_state_field(field),
      .hot_off_bus_select(sel), .bus_pwr_clk_ctl_enable(en), .bus_idle(bus_idle),
      .sec_clk(sec_clk), .sec_pwr_en(sec_pwr_en), .sec_rst_n(sec_rst_n),
      .sec_bus_hold(sec_bus_hold), .txn_allowed(txn_allowed), .bus_state(bus_state));
   sbp_func_model u_funcs (.core_clk(core_clk), .sec_pwr_en(sec_pwr_en), .sec_rst_n(sec_rst_n),
      .txn_allowed(txn_allowed), .want(want), .bus_idle(bus_idle));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic logic [1:0] exp_state(input logic [1:0] fs, input logic s, input logic e);
      if (!e)
         return 2'h0;
      if (fs == 2'h3)
         return s ? 2'h2 : 2'h3;
      return fs;
   endfunction
   task automatic check(input logic [1:0] seen, input logic [1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic go(input logic [1:0] fs, input logic s, input logic e);
      logic [1:0] x;
      int n;
      x = exp_state(fs, s, e);
      @(posedge core_clk);
      sel <= s;
      en <= e;
      want <= 1'b0;
      repeat (4) @(posedge core_clk);
      field <= fs;
      repeat (5) @(negedge core_clk);
      if (prev == 2'h3 && x != 2'h3)
         check(sec_rst_n, 2'h0);
      n = 0;
      while (bus_state !== x && n < 800) begin
         @(negedge core_clk);
         n++;
      end
      repeat (12) @(negedge core_clk);
      check(bus_state, x);
      check(sec_pwr_en, x != 2'h3);
      check(txn_allowed, x == 2'h0);
      check(sec_bus_hold, x == 2'h1 || x == 2'h2);
      if (x == 2'h2)
         check(sec_clk, 2'h0);
      prev = x;
      @(posedge core_clk);
      want <= seed[0];
   endtask
   initial begin
      #400000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      check(bus_state, 2'h0);
      repeat (3) @(negedge core_clk);
      check(txn_allowed, 2'h1);
      go(2'h1, 1'b1, 1'b1);
      go(2'h2, 1'b1, 1'b1);
      go(2'h3, 1'b1, 1'b1);
      go(2'h3, 1'b0, 1'b1);
      go(2'h0, 1'b0, 1'b1);
      go(2'h2, 1'b0, 1'b0);
      for (int i = 0; i < 14; i++) begin
         seed = xs(seed);
         go(seed[1:0], seed[2], seed[5:3] != 3'h0);
      end
      go(2'h0, 1'b1, 1'b1);
      @(posedge core_clk);
      field <= 2'h2;
      repeat (6) @(posedge core_clk);
      field <= 2'h0;
      repeat (40) @(negedge core_clk);
      check(bus_state, 2'h0);
      check(txn_allowed, 2'h1);
      print_verdict();
   end
endmodule
`default_nettype wire
